// ### oc_timer_pkg.sv
package oc_timer_pkg;

  // ==========================================================
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] count_register_addr = 4'h0;
  localparam logic [3:0] compare_zero_addr = 4'h1;
  localparam logic [3:0] compare_one_addr = 4'h2;
  localparam logic [3:0] control_zero_addr = 4'h3;
  localparam logic [3:0] control_one_addr = 4'h4;
  localparam logic [3:0] output_control_addr = 4'h5;
  localparam logic [3:0] pin_route_addr = 4'h6;
  localparam logic [3:0] irq_status_addr = 4'h7;
  localparam logic [3:0] irq_mask_addr = 4'h8;
  localparam logic [3:0] port_data_addr = 4'h9;

  // ==========================================================
  // Field positions
  localparam int run_bit_pos = 0;
  localparam int clk_sel_lsb = 1;
  localparam int cap_edge_lsb = 3;
  localparam int stop_hold_pos = 5;
  localparam int stop_level_pos = 6;
  localparam int capture_mode_pos = 7;
  localparam int clear_sel_pos = 0;
  localparam int match0_lsb = 4;
  localparam int match1_lsb = 6;
  localparam int invert_lsb = 6;
  localparam int irq_cmp0_pos = 0;
  localparam int irq_cmp1_pos = 1;
  localparam int irq_ovf_pos = 2;
  localparam int irq_cap_pos = 3;

  // ==========================================================
  // Reset values
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] compare_reset = 16'hFFFF;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] irq_reset = 4'h0;

  // ==========================================================
  // Prescaler divide counts for f8 and f32
  localparam logic [4:0] div8_last = 5'h07;
  localparam logic [4:0] div32_last = 5'h1F;

  typedef enum logic [1:0] {
    act_keep,
    act_low,
    act_high,
    act_toggle
  } match_action_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ### output_compare_timer.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Stopping the run bit clears the count
// - Clear on compare one match if selected
// - Reads return count and compare values
// - Writes to the count register are ignored
// - Six pin enables choose output pins
// - Per-match field sets high, low, toggle, keep
// - One invert bit per three-pin group
// - All pins share one compare waveform
// - Port data zero forces fixed pin level
// - Stopped pins hold or show stop level
// - Stopped: compare writes take effect at once
// - Free running: compare reload on overflow
// - Clear mode: compare reload at compare one
// - Capture edge interrupts even while stopped
// - Pin select routes fifth output to one of two pins
// - Separate compare0, compare1, overflow interrupts
// - Run bit starts and stops counting
module output_compare_timer #(
  parameter int width = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire oc_timer_pkg::reg_req_t req,
  output logic [15:0] rdata,
  // Capture input pin
  input wire logic capture_pin,
  // Compare output pins
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_n,
  output logic second_group_pin_b_alt,
  output logic second_group_pin_b_alt_oe_n,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Registers
  logic [width-1:0] count_reg;
  logic [width-1:0] cmp0_active_reg, cmp1_active_reg;
  logic [width-1:0] cmp0_buf_reg, cmp1_buf_reg;
  logic [7:0] ctrl0_reg, ctrl1_reg, out_ctrl_reg;
  logic [5:0] port_data_reg;
  logic alt_pin_select_reg;
  logic [3:0] irq_status_reg, irq_mask_reg;
  logic compare_out_reg;
  logic [5:0] pin_level_reg;
  logic [4:0] div_reg;
  logic tick_reg;
  logic cap_s1_reg, cap_s2_reg, cap_prev_reg;

  logic run, clear_sel, stop_hold, stop_level;
  logic match0, match1, overflow, cap_event;
  logic [1:0] clk_sel, cap_edge;
  logic [5:0] wave;

  assign run = ctrl0_reg[oc_timer_pkg::run_bit_pos];
  assign clk_sel = ctrl0_reg[oc_timer_pkg::clk_sel_lsb +: 2];
  assign cap_edge = ctrl0_reg[oc_timer_pkg::cap_edge_lsb +: 2];
  assign stop_hold = ctrl0_reg[oc_timer_pkg::stop_hold_pos];
  assign stop_level = ctrl0_reg[oc_timer_pkg::stop_level_pos];
  assign clear_sel = ctrl1_reg[oc_timer_pkg::clear_sel_pos];

  function automatic logic wr_to(input oc_timer_pkg::reg_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic apply_action(input logic cur, input logic [1:0] act);
    unique case (oc_timer_pkg::match_action_t'(act))
      oc_timer_pkg::act_keep: apply_action = cur;
      oc_timer_pkg::act_low: apply_action = 1'b0;
      oc_timer_pkg::act_high: apply_action = 1'b1;
      oc_timer_pkg::act_toggle: apply_action = ~cur;
    endcase
  endfunction

  // ==========================================================
  // Count source prescaler: f1, f8 or f32 as a one-cycle enable
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      div_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      unique case (clk_sel)
        2'h1: begin
          tick_reg <= (div_reg == oc_timer_pkg::div8_last);
          div_reg <= (div_reg == oc_timer_pkg::div8_last) ? 5'h00 : div_reg + 5'h01;
        end
        2'h2: begin
          tick_reg <= (div_reg == oc_timer_pkg::div32_last);
          div_reg <= div_reg + 5'h01;
        end
        default: begin
          tick_reg <= 1'b1;
          div_reg <= 5'h00;
        end
      endcase
    end
  end

  // Match and overflow only count in the tick cycle
  assign match0 = run && tick_reg && (count_reg == cmp0_active_reg);
  assign match1 = run && tick_reg && (count_reg == cmp1_active_reg);
  assign overflow = run && tick_reg && !(clear_sel && match1) && (&count_reg);

  // ==========================================================
  // Counter
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= oc_timer_pkg::count_reset;
    end else if (!run) begin
      count_reg <= oc_timer_pkg::count_reset;
    end else if (tick_reg) begin
      if (clear_sel && match1) begin
        count_reg <= oc_timer_pkg::count_reset;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
    // No write path to the count register
  end

  // ==========================================================
  // Compare buffers and active values
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp0_buf_reg <= oc_timer_pkg::compare_reset;
      cmp1_buf_reg <= oc_timer_pkg::compare_reset;
      cmp0_active_reg <= oc_timer_pkg::compare_reset;
      cmp1_active_reg <= oc_timer_pkg::compare_reset;
    end else begin
      if (wr_to(req, oc_timer_pkg::compare_zero_addr)) begin
        cmp0_buf_reg <= req.wdata;
      end
      if (wr_to(req, oc_timer_pkg::compare_one_addr)) begin
        cmp1_buf_reg <= req.wdata;
      end
      if (!run) begin
        // Stopped: the write goes straight through
        if (wr_to(req, oc_timer_pkg::compare_zero_addr)) begin
          cmp0_active_reg <= req.wdata;
        end else begin
          cmp0_active_reg <= cmp0_buf_reg;
        end
        if (wr_to(req, oc_timer_pkg::compare_one_addr)) begin
          cmp1_active_reg <= req.wdata;
        end else begin
          cmp1_active_reg <= cmp1_buf_reg;
        end
      end else if ((!clear_sel && overflow) || (clear_sel && match1)) begin
        cmp0_active_reg <= cmp0_buf_reg;
        cmp1_active_reg <= cmp1_buf_reg;
      end
    end
  end

  // ==========================================================
  // Control registers; writes are whole words
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl0_reg <= oc_timer_pkg::ctrl_reset;
      ctrl1_reg <= oc_timer_pkg::ctrl_reset;
      out_ctrl_reg <= oc_timer_pkg::ctrl_reset;
      port_data_reg <= 6'h3F;
      alt_pin_select_reg <= 1'b0;
      irq_mask_reg <= oc_timer_pkg::irq_reset;
    end else begin
      if (wr_to(req, oc_timer_pkg::control_zero_addr)) begin
        ctrl0_reg <= req.wdata[7:0];
      end
      if (wr_to(req, oc_timer_pkg::control_one_addr)) begin
        ctrl1_reg <= req.wdata[7:0];
      end
      if (wr_to(req, oc_timer_pkg::output_control_addr)) begin
        out_ctrl_reg <= req.wdata[7:0];
      end
      if (wr_to(req, oc_timer_pkg::port_data_addr)) begin
        port_data_reg <= req.wdata[5:0];
      end
      if (wr_to(req, oc_timer_pkg::pin_route_addr)) begin
        alt_pin_select_reg <= req.wdata[0];
      end
      if (wr_to(req, oc_timer_pkg::irq_mask_addr)) begin
        irq_mask_reg <= req.wdata[3:0];
      end
    end
  end

  // ==========================================================
  // Capture input: two-stage sync, then edge detect
  always_ff @(posedge clk) begin
    if (srst) begin
      cap_s1_reg <= 1'b0;
      cap_s2_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      cap_s1_reg <= capture_pin;
      cap_s2_reg <= cap_s1_reg;
      cap_prev_reg <= cap_s2_reg;
    end
  end

  // Edge select: 0 rising, 1 falling, 2 or 3 both; independent of run
  assign cap_event = ctrl0_reg[oc_timer_pkg::capture_mode_pos] &&
    ((cap_edge == 2'h0) ? (cap_s2_reg && !cap_prev_reg) :
     (cap_edge == 2'h1) ? (!cap_s2_reg && cap_prev_reg) :
     (cap_s2_reg != cap_prev_reg));

  // ==========================================================
  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status_reg <= oc_timer_pkg::irq_reset;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg &
        ~(wr_to(req, oc_timer_pkg::irq_status_addr) ? req.wdata[3:0] : 4'h0)) |
        {cap_event, overflow, match1, match0};
      irq <= |((irq_status_reg | {cap_event, overflow, match1, match0}) & irq_mask_reg);
    end
  end

  // ==========================================================
  // Internal compare waveform
  always_ff @(posedge clk) begin
    if (srst) begin
      compare_out_reg <= 1'b0;
    end else if (match0 || match1) begin
      // Compare 1 action applied last, to the compare 0 result, when both match together
      compare_out_reg <= apply_action(
        match0 ? apply_action(compare_out_reg, ctrl1_reg[oc_timer_pkg::match0_lsb +: 2])
               : compare_out_reg,
        match1 ? ctrl1_reg[oc_timer_pkg::match1_lsb +: 2] : 2'h0);
    end
  end

  // Pins follow the waveform one cycle after it changes, in both groups
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (port_data_reg[i]) begin
        wave[i] = compare_out_reg ^ out_ctrl_reg[oc_timer_pkg::invert_lsb + i / 3];
      end else begin
        wave[i] = out_ctrl_reg[oc_timer_pkg::invert_lsb + i / 3];
      end
    end
  end

  // ==========================================================
  // Pin levels and enables
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_level_reg <= 6'h00;
      pin_out <= 6'h00;
      pin_oe_n <= 6'h3F;
      second_group_pin_b_alt <= 1'b0;
      second_group_pin_b_alt_oe_n <= 1'b1;
    end else begin
      if (run) begin
        pin_level_reg <= wave;
      end else if (stop_hold) begin
        pin_level_reg <= {6{stop_level}};
      end
      pin_out <= run ? wave : (stop_hold ? {6{stop_level}} : pin_level_reg);
      pin_oe_n <= ~out_ctrl_reg[5:0];
      // Fifth output goes to the main or the alternative pin
      pin_oe_n[4] <= ~(out_ctrl_reg[4] && !alt_pin_select_reg);
      second_group_pin_b_alt <= run ? wave[4] : (stop_hold ? stop_level : pin_level_reg[4]);
      second_group_pin_b_alt_oe_n <= ~(out_ctrl_reg[4] && alt_pin_select_reg);
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; zero otherwise
  always_ff @(posedge clk) begin
    if (srst || !req.rd) begin
      rdata <= 16'h0000;
    end else begin
      unique case (req.addr)
        oc_timer_pkg::count_register_addr: rdata <= count_reg;
        oc_timer_pkg::compare_zero_addr: rdata <= cmp0_active_reg;
        oc_timer_pkg::compare_one_addr: rdata <= cmp1_active_reg;
        oc_timer_pkg::control_zero_addr: rdata <= {8'h00, ctrl0_reg};
        oc_timer_pkg::control_one_addr: rdata <= {8'h00, ctrl1_reg};
        oc_timer_pkg::output_control_addr: rdata <= {8'h00, out_ctrl_reg};
        oc_timer_pkg::pin_route_addr: rdata <= {15'h0000, alt_pin_select_reg};
        oc_timer_pkg::irq_status_addr: rdata <= {12'h000, irq_status_reg};
        oc_timer_pkg::irq_mask_addr: rdata <= {12'h000, irq_mask_reg};
        oc_timer_pkg::port_data_addr: rdata <= {10'h000, port_data_reg};
        default: rdata <= 16'h0000;
      endcase
    end
  end

endmodule // output_compare_timer

// ### output_compare_timer_monitor.sv
`timescale 1ns/10ps
// ==========
// Port-side checks
module output_compare_timer_monitor #(
  parameter int width = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire oc_timer_pkg::reg_req_t req,
  input wire logic [15:0] rdata,
  // Pins
  input wire logic capture_pin,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic second_group_pin_b_alt,
  input wire logic second_group_pin_b_alt_oe_n,
  input wire logic irq
);
  logic [7:0] c0_reg, oc_reg;
  logic [5:0] pd_reg, inv, en, wav;
  logic [3:0] mk_reg;
  logic [2:0] age_reg;
  logic alt_reg, oc;
  // Shadow of written config, so pin checks need no view of the body
  always_ff @(posedge clk) begin
    if (srst) begin
      c0_reg <= 8'h00;
      oc_reg <= 8'h00;
      pd_reg <= 6'h3F;
      mk_reg <= 4'h0;
      alt_reg <= 1'b0;
    end else if (req.wr) begin
      case (req.addr)
        4'h3: c0_reg <= req.wdata[7:0];
        4'h5: oc_reg <= req.wdata[7:0];
        4'h6: alt_reg <= req.wdata[0];
        4'h8: mk_reg <= req.wdata[3:0];
        4'h9: pd_reg <= req.wdata[5:0];
        default: ;
      endcase
    end
  end
  // Pins are registered twice over; checks wait until config has been quiet 4 cycles
  always_ff @(posedge clk) begin
    if (srst || (req.wr && req.addr inside {4'h3, 4'h5, 4'h6, 4'h8, 4'h9})) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h4) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  assign oc = !c0_reg[7] && age_reg == 3'h4;
  assign inv = {{3{oc_reg[7]}}, {3{oc_reg[6]}}};
  assign en = oc_reg[5:0];
  assign wav = (pin_out ^ inv) & en & pd_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_RDATA_IDLE: assert property (
    !$past(req.rd) |-> rdata == 16'h0000) else $error("rdata not idle");
  AST_STOP_COUNT: assert property (
    req.rd && req.addr == 4'h0 && oc && !c0_reg[0] |=> rdata == 16'h0000)
    else $error("count not zero while stopped");
  AST_PIN_ENABLE: assert property (
    oc |-> {pin_oe_n[5], pin_oe_n[3:0]} == ~{en[5], en[3:0]}) else $error("pin enable");
  AST_ALT_ROUTE: assert property (
    oc |-> pin_oe_n[4] == !(en[4] && !alt_reg)
      && second_group_pin_b_alt_oe_n == !(en[4] && alt_reg)) else $error("alt route");
  AST_SAME_WAVE: assert property (
    oc && c0_reg[0] |-> wav == 6'h00 || wav == (en & pd_reg)) else $error("waves differ");
  AST_FIXED_LEVEL: assert property (
    oc && c0_reg[0] |-> ((pin_out ^ inv) & en & ~pd_reg) == 6'h00) else $error("fixed level");
  AST_STOP_LEVEL: assert property (
    oc && !c0_reg[0] && c0_reg[5] |-> (pin_out & en & pd_reg) == (c0_reg[6] ? en & pd_reg : 6'h00))
    else $error("stop level");
  AST_STOP_HOLD: assert property (
    oc && !c0_reg[0] && !c0_reg[5] |-> $stable(pin_out & en)) else $error("stop hold");
  AST_IRQ_MASKED: assert property (
    age_reg == 3'h4 && mk_reg == 4'h0 |-> !irq) else $error("irq while masked");
  cover property (irq);
  cover property (oc && c0_reg[0] && wav != 6'h00);
  cover property (!second_group_pin_b_alt_oe_n);
endmodule // output_compare_timer_monitor
bind output_compare_timer output_compare_timer_monitor #(.width(width)) u_mon (
  .clk(clk), .srst(srst), .req(req), .rdata(rdata), .capture_pin(capture_pin),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .second_group_pin_b_alt(second_group_pin_b_alt),
  .second_group_pin_b_alt_oe_n(second_group_pin_b_alt_oe_n), .irq(irq));

// ### pin_load.sv
`timescale 1ns/10ps
// ==========
// Load on the compare pins
module pin_load (
  // Pins from the timer
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  // Levels seen by the load
  output logic [5:0] sense
);
  // Weak pull-down: a released pin reads low, never its last driven value
  assign sense = pin_out & ~pin_oe_n;
endmodule // pin_load

// ### test_output_compare_timer.sv
`timescale 1ns/10ps
// ==========
// Bench
module test_output_compare_timer;
  logic clk = 1'b0;
  logic srst = 1'b1;
  oc_timer_pkg::reg_req_t req = '0;
  logic capture_pin = 1'b0;
  logic [15:0] rdata, got, g2;
  logic [5:0] pin_out, pin_oe_n, sense;
  logic alt, alt_oe_n, irq, s1;
  int fails = 0;
  int n_tests = 0;
  int k;
  initial begin
    forever #2.5 clk = ~clk;
  end
  output_compare_timer u_dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .capture_pin(capture_pin), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .second_group_pin_b_alt(alt), .second_group_pin_b_alt_oe_n(alt_oe_n), .irq(irq));
  pin_load u_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .sense(sense));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Whole words only: one strobe carries all 16 bits
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Overflow at full width needs about 66k cycles; the rest is short
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rc("count", 4'h0, 16'h0000);
    rc("cmp0", 4'h1, 16'hFFFF);
    rc("cmp1", 4'h2, 16'hFFFF);
    rc("unmapped", 4'hF, 16'h0000);
    wr(4'h0, 16'h1234);
    rc("count write", 4'h0, 16'h0000);
    wr(4'h1, 16'h0010);
    rc("cmp0 stopped", 4'h1, 16'h0010);
    wr(4'h8, 16'h0004);
    wr(4'h3, 16'h0001);
    tk(4);
    rd(4'h0, got);
    rd(4'h0, g2);
    chk("count step", g2 - got, 16'h0002);
    wr(4'h1, 16'h0020);
    rc("cmp0 buffered", 4'h1, 16'h0010);
    k = 0;
    while (irq !== 1'b1 && k < 70000) begin
      @(posedge clk);
      k++;
    end
    chk("overflow irq", irq, 16'h0001);
    rc("cmp0 reload", 4'h1, 16'h0020);
    rd(4'h7, got);
    chk("overflow status", got[2], 16'h0001);
    wr(4'h7, 16'h000F);
    wr(4'h3, 16'h0000);
    rc("count stop", 4'h0, 16'h0000);
    chk("irq clear", irq, 16'h0000);
    wr(4'h2, 16'h0007);
    wr(4'h4, 16'h0001);
    wr(4'h8, 16'h0002);
    wr(4'h3, 16'h0001);
    for (k = 0; k < 4; k++) begin
      rd(4'h0, got);
      chk("clear count", got <= 16'h0007, 16'h0001);
    end
    tk(10);
    chk("cmp1 irq", irq, 16'h0001);
    wr(4'h8, 16'h0000);
    tk(2);
    chk("masked irq", irq, 16'h0000);
    wr(4'h2, 16'h0003);
    tk(12);
    rc("cmp1 reload", 4'h2, 16'h0003);
    rd(4'h0, got);
    chk("short period", got <= 16'h0003, 16'h0001);
    wr(4'h3, 16'h0020);
    wr(4'h1, 16'h0002);
    wr(4'h2, 16'h0005);
    wr(4'h5, 16'h00BF);
    // One pass per match action: keep, low, high, toggle
    for (k = 0; k < 4; k++) begin
      wr(4'h3, 16'h0020);
      wr(4'h4, 16'(k * 16 + 1));
      wr(4'h3, 16'h0021);
      tk(20);
      s1 = sense[0];
      chk("group invert", sense[3], !s1);
      tk(6);
      chk("match action", sense[0], k == 0 ? s1 : k == 3 ? !s1 : k == 2);
    end
    wr(4'h9, 16'h0036);
    tk(4);
    chk("forced low", sense[0], 16'h0000);
    chk("forced high", sense[3], 16'h0001);
    wr(4'h9, 16'h003F);
    wr(4'h3, 16'h0060);
    tk(4);
    chk("stop high", sense[3], 16'h0001);
    wr(4'h3, 16'h0020);
    tk(4);
    chk("stop low", sense[3], 16'h0000);
    wr(4'h6, 16'h0001);
    tk(4);
    chk("alt pin", {alt_oe_n, pin_oe_n[4]}, 16'h0001);
    chk("alt level", alt, 16'h0000);
    wr(4'h7, 16'h000F);
    wr(4'h8, 16'h0008);
    wr(4'h3, 16'h0080);
    capture_pin <= 1'b1;
    tk(8);
    chk("capture irq", irq, 16'h0001);
    tally_and_finish();
  end
endmodule // test_output_compare_timer
